//--- adc_control_and_readout.sv
// converter control and readout block with an axi4-lite register slave
// Summary of operation
// - conversion clock drives state machine; gaps corrupt
// - calibration lasts 272800 conversion clock cycles
// - data meaningless during reset/cal plus 13
// - output drivers enabled only while read_n low
// - power_down_n low forces standby
// - wake within wake_up_time after power_down_n high
// - pipeline emptied by power-down
// - valid_n low marks valid data
// - fourteen bit two's complement result
// - sample falling edge, out 13 later
// - one result per conversion clock
// - out-of-range inputs saturate to full scale
`timescale 1ns/1ps
`default_nettype none
module adc_control_and_readout #(
    parameter int CAL_LEN = conv_pkg::CAL_CYCLES,
    parameter int WAKE_LEN = conv_pkg::WAKE_UP_CYCLES
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // conversion clock and analog sample from outside
    input wire logic conv_clk,
    input wire logic signed [15:0] analog_in,
    // pins, also driven from the control register when pin_mode is low
    input wire logic reset_pin,
    input wire logic cal_pin,
    input wire logic read_n,
    input wire logic power_down_n,
    // parallel result pins
    output logic [conv_pkg::SAMPLE_WIDTH-1:0] data_out,
    output logic data_oe,
    output logic valid_n,
    // axi4-lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    localparam int W = conv_pkg::SAMPLE_WIDTH;
    localparam logic signed [15:0] POS_FS = 16'sh1FFF;
    localparam logic signed [15:0] NEG_FS = -16'sh2000;

    typedef enum logic [2:0] {
        ST_RESET, ST_IDLE, ST_CAL, ST_RUN, ST_STANDBY, ST_WAKE
    } conv_state_e;

    initial begin
        // the shared cycle counter is 19 bits wide
        if (CAL_LEN < 1 || WAKE_LEN < 1 || CAL_LEN > 524288
            || WAKE_LEN > 524288) $error("bad count parameters");
    end

    // three-stage synchronisers for pins and conversion clock
    logic [2:0] s_clk, s_rst, s_cal, s_rd, s_pd;
    logic clk_q, rst_q, cal_q, rd_q, pd_q;
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            s_clk <= '0;
            s_rst <= '0;
            s_cal <= '0;
            s_rd <= '1;
            s_pd <= '1;
        end else begin
            s_clk <= {s_clk[1:0], conv_clk};
            s_rst <= {s_rst[1:0], reset_pin};
            s_cal <= {s_cal[1:0], cal_pin};
            s_rd <= {s_rd[1:0], read_n};
            s_pd <= {s_pd[1:0], power_down_n};
        end
    end

    // a change counts only once stages two and three agree
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            clk_q <= 1'b0;
            rst_q <= 1'b0;
            cal_q <= 1'b0;
            rd_q <= 1'b1;
            pd_q <= 1'b1;
        end else begin
            if (s_clk[1] == s_clk[2]) clk_q <= s_clk[2];
            if (s_rst[1] == s_rst[2]) rst_q <= s_rst[2];
            if (s_cal[1] == s_cal[2]) cal_q <= s_cal[2];
            if (s_rd[1] == s_rd[2]) rd_q <= s_rd[2];
            if (s_pd[1] == s_pd[2]) pd_q <= s_pd[2];
        end
    end

    // control register: software may override the pins
    logic [3:0] ctrl;
    logic pin_mode;
    logic eff_rst, eff_cal, eff_rd_n, eff_pd_n;
    assign eff_rst = pin_mode ? rst_q : ctrl[conv_pkg::CTRL_RESET_BIT];
    assign eff_cal = pin_mode ? cal_q : ctrl[conv_pkg::CTRL_CAL_BIT];
    assign eff_rd_n = pin_mode ? rd_q : ctrl[conv_pkg::CTRL_READ_N_BIT];
    assign eff_pd_n = pin_mode ? pd_q : ctrl[conv_pkg::CTRL_PD_N_BIT];

    // converter logic steps on conversion clock edges; power-down entry, pipeline flush and valid_n clearing act on any sys_clk cycle
    logic clk_prev, rise, fall;
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) clk_prev <= 1'b0;
        else clk_prev <= clk_q;
    end
    assign rise = clk_q & ~clk_prev;
    assign fall = ~clk_q & clk_prev;

    conv_state_e state;
    logic [18:0] count;
    logic [1:0] rst_len, cal_len;
    logic [3:0] quiet;
    logic was_reset;
    logic flush;

    // reset and calibration levels count as seen only after two whole clock cycles
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rst_len <= '0;
            cal_len <= '0;
        end else if (rise) begin
            rst_len <= eff_rst ? (rst_len == 2'h3 ? rst_len : rst_len + 2'h1)
                               : 2'h0;
            cal_len <= eff_cal ? (cal_len == 2'h3 ? cal_len : cal_len + 2'h1)
                               : 2'h0;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state <= ST_RESET;
            count <= '0;
            was_reset <= 1'b0;
        end else if (!eff_pd_n) begin
            state <= ST_STANDBY;
            count <= '0;
            was_reset <= 1'b0;
        end else if (rise) begin
            unique case (state)
                ST_STANDBY: begin
                    state <= ST_WAKE;
                    count <= '0;
                end
                ST_WAKE: begin
                    count <= count + 19'h1;
                    if (count == 19'(WAKE_LEN - 1)) state <= ST_RUN;
                end
                ST_RESET, ST_IDLE, ST_RUN: begin
                    if (rst_len >= 2'(conv_pkg::RESET_MIN_CYCLES - 1)
                        && eff_rst) begin
                        state <= ST_RESET;
                        was_reset <= 1'b1;
                    end else if (eff_rst) begin
                        state <= state;
                    end else if (state == ST_RESET) begin
                        state <= ST_IDLE;
                    end else if (was_reset && eff_cal && cal_len >=
                                 2'(conv_pkg::CAL_MIN_CYCLES - 1)) begin
                        state <= ST_CAL;
                        count <= '0;
                        was_reset <= 1'b0;
                    end else begin
                        state <= ST_RUN;
                    end
                end
                ST_CAL: begin
                    if (!eff_cal) count <= count + 19'h1;
                    if (!eff_cal && count == 19'(CAL_LEN - 1))
                        state <= ST_RUN;
                end
                default: begin
                    state <= ST_RESET;
                end
            endcase
        end
    end

    // quiet period after reset or calibration release
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            quiet <= 4'(conv_pkg::PIPE_DEPTH);
        end else if (eff_rst || eff_cal || state == ST_CAL
                     || state == ST_STANDBY) begin
            quiet <= 4'(conv_pkg::PIPE_DEPTH);
        end else if (rise && quiet != 4'h0) begin
            quiet <= quiet - 4'h1;
        end
    end
    assign flush = eff_rst || state == ST_STANDBY;

    // saturating quantiser
    logic [W-1:0] code;
    always_comb begin
        if (analog_in > POS_FS) code = POS_FS[W-1:0];
        else if (analog_in < NEG_FS) code = NEG_FS[W-1:0];
        else code = analog_in[W-1:0];
    end

    logic [W-1:0] result;
    logic result_ok;
    conv_pipe #(.WIDTH(W), .DEPTH(conv_pkg::PIPE_DEPTH)) pipe (
        .sys_clk(sys_clk),
        .reset(reset),
        .flush(flush),
        .sample_now(fall),
        .sample_in(code),
        .result(result),
        .result_ok(result_ok)
    );

    // output on rising edge so the host can latch the next one
    logic good;
    assign good = result_ok && quiet == 4'h0 && state == ST_RUN;
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            data_out <= '0;
            valid_n <= 1'b1;
        end else begin
            if (rise) data_out <= result;
            if (rise) valid_n <= ~good;
            if (eff_rst) valid_n <= 1'b1;
        end
    end
    assign data_oe = ~eff_rd_n;

    // axi4-lite slave; one write and one read outstanding at a time
    logic aw_held, w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
    assign s_axi_wready = ~w_held & ~s_axi_bvalid;
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= conv_pkg::RESP_OKAY;
            ctrl <= conv_pkg::CTRL_RESET_VALUE;
            pin_mode <= 1'b1;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (aw_held && w_held) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (aw_addr == conv_pkg::CTRL_OFFSET) begin
                    s_axi_bresp <= conv_pkg::RESP_OKAY;
                    if (w_strb[0]) begin
                        ctrl <= w_data[3:0];
                        pin_mode <= w_data[4];
                    end
                end else if (aw_addr == conv_pkg::STATUS_OFFSET
                             || aw_addr == conv_pkg::SAMPLE_OFFSET) begin
                    s_axi_bresp <= conv_pkg::RESP_OKAY;
                end else begin
                    s_axi_bresp <= conv_pkg::RESP_DECERR;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    assign s_axi_arready = ~s_axi_rvalid;
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= conv_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= conv_pkg::RESP_OKAY;
            unique case (s_axi_araddr)
                conv_pkg::CTRL_OFFSET:
                    s_axi_rdata <= {27'h0, pin_mode, ctrl};
                conv_pkg::STATUS_OFFSET:
                    s_axi_rdata <= {28'h0, state == ST_RESET,
                                    state == ST_STANDBY, state == ST_CAL,
                                    ~valid_n};
                conv_pkg::SAMPLE_OFFSET:
                    s_axi_rdata <= {{(32-W){data_out[W-1]}}, data_out};
                default: begin
                    s_axi_rdata <= '0;
                    s_axi_rresp <= conv_pkg::RESP_DECERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule // adc_control_and_readout
`default_nettype wire

//--- adc_control_and_readout_assertions.sv
// protocol checker for the converter control and readout block
`timescale 1ns/1ps
`default_nettype none
module adc_control_and_readout_assertions #(
    parameter int CAL_LEN = 20,
    parameter int WAKE_LEN = 2
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // converter pins
    input wire logic reset_pin,
    input wire logic cal_pin,
    input wire logic read_n,
    input wire logic power_down_n,
    input wire logic [conv_pkg::SAMPLE_WIDTH-1:0] data_out,
    input wire logic data_oe,
    input wire logic valid_n,
    // register bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    logic [3:0] up;
    logic [6:0] busy;
    // pin synchronisers need time after reset before the pins count
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) up <= 4'h0;
        else if (up != 4'hF) up <= up + 4'h1;
    end
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) busy <= 7'h00;
        else if (!(reset_pin || cal_pin || !power_down_n)) busy <= 7'h00;
        else if (busy != 7'h7F) busy <= busy + 7'h01;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    sequence aw_w_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence ar_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    chk_oe_follows_pin: assert property (
        (up == 4'hF && $stable(read_n)) [*6] |-> data_oe == !read_n)
        else $error("data_oe does not follow read_n");
    chk_hold_forces_invalid: assert property (
        busy >= 7'h5A |-> valid_n) else $error("valid_n low while held");
    chk_valid_after_calm: assert property (
        $fell(valid_n) |-> !reset_pin && !cal_pin && power_down_n
        && !$past(reset_pin, 8) && !$past(cal_pin, 8))
        else $error("valid_n fell too soon");
    chk_one_word_cycle: assert property (
        $changed(data_out) |=> $stable(data_out) [*8])
        else $error("data_out changed twice in a conversion cycle");
    chk_write_answer: assert property (aw_w_taken |-> ##2 s_axi_bvalid)
        else $error("write response late");
    chk_read_answer: assert property (
        ar_taken |=> s_axi_rvalid && !s_axi_arready)
        else $error("read response late");
    chk_write_refused: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    chk_resp_clears: assert property (
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read response not cleared");
endmodule // adc_control_and_readout_assertions
bind adc_control_and_readout adc_control_and_readout_assertions #(
    .CAL_LEN(CAL_LEN), .WAKE_LEN(WAKE_LEN)) chk_u (.*);
`default_nettype wire

//--- conv_pipe.sv
// result pipeline of the converter with a validity mark per stage
`timescale 1ns/1ps
`default_nettype none
module conv_pipe #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 13
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // control
    input wire logic flush,
    input wire logic sample_now,
    // data
    input wire logic [WIDTH-1:0] sample_in,
    output logic [WIDTH-1:0] result,
    output logic result_ok
);
    logic [WIDTH-1:0] word [DEPTH];
    logic [DEPTH-1:0] ok;

    initial begin
        if (DEPTH < 2 || WIDTH < 2) $error("conv_pipe: bad size");
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            ok <= '0;
        end else if (flush) begin
            ok <= '0;
        end else if (sample_now) begin
            ok <= {ok[DEPTH-2:0], 1'b1};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sample_now) begin
            word[0] <= sample_in;
            for (int i = 1; i < DEPTH; i++) begin
                word[i] <= word[i-1];
            end
        end
    end

    assign result = word[DEPTH-1];
    assign result_ok = ok[DEPTH-1];
endmodule // conv_pipe
`default_nettype wire

//--- conv_pkg.sv
// constants for the converter control and readout block
`default_nettype none
package conv_pkg;
    localparam int SAMPLE_WIDTH = 14;
    localparam int PIPE_DEPTH = 13;
    localparam int CAL_CYCLES = 272800;
    localparam int RESET_MIN_CYCLES = 2;
    localparam int CAL_MIN_CYCLES = 2;
    localparam int WAKE_UP_CYCLES = 16;
    // register byte offsets
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] SAMPLE_OFFSET = 8'h08;
    localparam logic [7:0] ANALOG_OFFSET = 8'h0C;
    // control field positions
    localparam int CTRL_RESET_BIT = 0;
    localparam int CTRL_CAL_BIT = 1;
    localparam int CTRL_READ_N_BIT = 2;
    localparam int CTRL_PD_N_BIT = 3;
    localparam logic [3:0] CTRL_RESET_VALUE = 4'hC;
    // status field positions
    localparam int ST_VALID_BIT = 0;
    localparam int ST_CAL_BIT = 1;
    localparam int ST_PD_BIT = 2;
    localparam int ST_RESET_BIT = 3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage
`default_nettype wire

//--- host_model.sv
// host controller model: conversion clock, reset, calibration, capture
`timescale 1ns/1ps
`default_nettype none
module host_model #(
    parameter int HALF = 25,
    parameter int SETTLE = 4
) (
    // clock
    input wire logic sys_clk,
    // converter pins
    output logic conv_clk,
    output logic reset_pin,
    output logic cal_pin,
    input wire logic [conv_pkg::SAMPLE_WIDTH-1:0] data_out,
    input wire logic valid_n,
    // captured word
    output logic [conv_pkg::SAMPLE_WIDTH-1:0] word
);
    int div = 0;
    initial conv_clk = 1'b0;
    initial reset_pin = 1'b0;
    initial cal_pin = 1'b0;
    initial word = '0;
    // free running at 2.5 MHz, never gated: a gap spoils the pipeline
    always @(posedge sys_clk) begin
        div <= (div == HALF - 1) ? 0 : div + 1;
        if (div == HALF - 1) conv_clk <= !conv_clk;
    end
    always @(posedge conv_clk) begin
        if (valid_n === 1'b0) word <= data_out;
    end
    task automatic cycles(input int n);
        repeat (n) @(posedge conv_clk);
    endtask
    // no done flag exists, so callers count conversion cycles
    task automatic reset_and_cal();
        // start on a clock edge so the pulse spans two whole cycles
        cycles(1);
        reset_pin <= 1'b1;
        cycles(2);
        reset_pin <= 1'b0;
        cycles(SETTLE);
        cal_pin <= 1'b1;
        cycles(2);
        cal_pin <= 1'b0;
    endtask
endmodule // host_model
`default_nettype wire

//--- testbench.sv
// self-checking testbench for the converter control and readout block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int CAL_LEN = 20;
    localparam int WAKE_LEN = 2;
    logic sys_clk, reset, read_n, power_down_n;
    logic conv_clk, reset_pin, cal_pin, data_oe, valid_n;
    logic signed [15:0] analog_in;
    logic [13:0] data_out, word;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    int fail_count, n_tests;
    adc_control_and_readout #(.CAL_LEN(CAL_LEN), .WAKE_LEN(WAKE_LEN))
        dut_u (.*);
    host_model host_u (.*);
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = !sys_clk;
    end
    task automatic close_out();
        if (fail_count == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic check_val(input string what, input logic [31:0] e, g);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic check_count(input string what, input int lo, hi, g);
        n_tests++;
        if (g < lo || g > hi) begin
            fail_count++;
            $display("wrong value %s expected %0d..%0d seen %0d",
                     what, lo, hi, g);
        end
    endtask
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                             output logic [1:0] r);
        logic aw, w;
        @(posedge sys_clk);
        aw = 1'b0;
        w = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw && w)) begin
            @(posedge sys_clk);
            aw = aw || (s_axi_awvalid && s_axi_awready);
            w = w || (s_axi_wvalid && s_axi_wready);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
        end
        while (s_axi_bvalid !== 1'b1) @(posedge sys_clk);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                            output logic [1:0] r);
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        while (s_axi_rvalid !== 1'b1) @(posedge sys_clk);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic t_regs();
        axi_read(conv_pkg::CTRL_OFFSET, rd, rs);
        check_val("ctrl reset", 32'(conv_pkg::CTRL_RESET_VALUE), 32'(rd[3:0]));
        axi_write(conv_pkg::CTRL_OFFSET, 32'h0000001C, rs);
        check_val("ctrl bresp", 32'(conv_pkg::RESP_OKAY), 32'(rs));
        axi_read(conv_pkg::CTRL_OFFSET, rd, rs);
        check_val("ctrl back", 32'h0000001C, 32'(rd[4:0]));
        // a write with byte lane zero off must leave control untouched
        s_axi_wstrb <= 4'h0;
        axi_write(conv_pkg::CTRL_OFFSET, 32'h00000000, rs);
        s_axi_wstrb <= 4'hF;
        check_val("masked bresp", 32'(conv_pkg::RESP_OKAY), 32'(rs));
        axi_read(conv_pkg::CTRL_OFFSET, rd, rs);
        check_val("ctrl masked", 32'h0000001C, 32'(rd[4:0]));
        axi_write(conv_pkg::ANALOG_OFFSET, 32'h00000005, rs);
        check_val("hole bresp", 32'(conv_pkg::RESP_DECERR), 32'(rs));
        axi_read(conv_pkg::ANALOG_OFFSET, rd, rs);
        check_val("hole rresp", 32'(conv_pkg::RESP_DECERR), 32'(rs));
        check_val("hole rdata", 32'h00000000, rd);
    endtask
    // counts conversion cycles from calibration release to first valid word
    task automatic wait_valid(output int n);
        n = 0;
        while (valid_n !== 1'b0 && n < 100) begin
            host_u.cycles(1);
            n++;
        end
    endtask
    task automatic t_cal_stream();
        logic signed [15:0] ins [4] = '{16'sd1234, -16'sd77, 16'sd9000,
                                        -16'sd9000};
        logic [13:0] outs [4] = '{14'h04D2, 14'h3FB3, 14'h1FFF, 14'h2000};
        int n;
        host_u.reset_and_cal();
        wait_valid(n);
        check_count("cal length", CAL_LEN + 13, CAL_LEN + 16, n);
        for (int i = 0; i < 4; i++) begin
            analog_in <= ins[i];
            host_u.cycles(16);
            check_val("result", 32'(outs[i]), 32'(word));
        end
        axi_read(conv_pkg::SAMPLE_OFFSET, rd, rs);
        check_val("sample reg", 32'hFFFFE000, rd);
        host_u.cycles(1);
        analog_in <= 16'sd100;
        n = 0;
        while (data_out === 14'h2000 && n < 40) begin
            host_u.cycles(1);
            n++;
        end
        check_count("latency", 14, 15, n);
    endtask
    task automatic t_output_enable();
        read_n <= 1'b1;
        repeat (8) @(posedge sys_clk);
        check_val("oe off", 32'h0, 32'(data_oe));
        read_n <= 1'b0;
        repeat (8) @(posedge sys_clk);
        check_val("oe on", 32'h1, 32'(data_oe));
    endtask
    task automatic t_power_down();
        int n;
        power_down_n <= 1'b0;
        host_u.cycles(5);
        check_val("standby valid_n", 32'h1, 32'(valid_n));
        axi_read(conv_pkg::STATUS_OFFSET, rd, rs);
        check_val("standby flag", 32'h1, 32'(rd[2]));
        power_down_n <= 1'b1;
        n = 0;
        repeat (conv_pkg::PIPE_DEPTH) begin
            host_u.cycles(1);
            if (valid_n !== 1'b1) n++;
        end
        check_count("early valid", 0, 0, n);
        host_u.reset_and_cal();
        wait_valid(n);
        check_count("wake cal", CAL_LEN + 13, CAL_LEN + 16, n);
        host_u.cycles(3);
        check_val("wake word", 32'h00000064, 32'(word));
    endtask
    initial begin
        reset = 1'b1;
        read_n = 1'b0;
        power_down_n = 1'b1;
        analog_in = 16'sd0;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h00000000;
        s_axi_wstrb = 4'hF;
        s_axi_awvalid = 1'b0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        fail_count = 0;
        n_tests = 0;
        repeat (4) @(posedge sys_clk);
        reset <= 1'b0;
        t_regs();
        t_cal_stream();
        t_output_enable();
        t_power_down();
        close_out();
    end
    // whole run needs about 9500 cycles
    initial begin
        repeat (40000) @(posedge sys_clk);
        fail_count++;
        close_out();
    end
endmodule // testbench
`default_nettype wire
